// ---- src/spi_master_pkg.sv ----
// package for the serial master port: register map, field layout,
// reset values, timing counts and the state carriers.
// assumes a 10 MHz system clock and an APB register bus with 32-bit data.
package spi_master_pkg;

  // ==========================================================
  // timing
  localparam int unsigned SYS_CLK_HZ     = 10_000_000;
  localparam int unsigned SYS_PERIOD_NS  = 1_000_000_000 / SYS_CLK_HZ;
  localparam int unsigned MIN_SCLK_SYS   = 4;
  localparam logic [15:0] MIN_HALF       = 16'(MIN_SCLK_SYS / 2);

  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CLOCK_DIVIDER   = 16'h3000;
  localparam logic [15:0] IDX_CLOCK_CONTROL   = 16'h3001;
  localparam logic [15:0] IDX_DEVICE_CONFIG_1 = 16'h3002;
  localparam logic [15:0] IDX_DEVICE_CONFIG_2 = 16'h3003;
  localparam logic [15:0] IDX_COMMAND_1       = 16'h3004;
  localparam logic [15:0] IDX_COMMAND_2       = 16'h3005;
  localparam logic [15:0] IDX_STATUS_1        = 16'h3006;
  localparam logic [15:0] IDX_STATUS_2        = 16'h3007;
  localparam logic [15:0] IDX_DATA_1          = 16'h3008;
  localparam logic [15:0] IDX_DATA_2          = 16'h3009;
  localparam logic [15:0] IDX_IRQ_STATUS      = 16'h300A;
  localparam logic [15:0] IDX_IRQ_MASK        = 16'h300B;

  // ==========================================================
  // fields
  localparam int CCR_ENABLE   = 0;
  localparam int DCR_STRIDE   = 8;
  localparam int DCR_POL      = 0;
  localparam int DCR_PHA      = 1;
  localparam int DCR_CS_HIGH  = 2;
  localparam int DCR_DLY_LO   = 3;
  localparam int CMD1_FLEN_W  = 12;
  localparam int CMD1_CHAR_IE = 14;
  localparam int CMD1_FRAME_IE = 15;
  localparam int CMD2_START   = 0;
  localparam int CMD2_LOOP    = 1;
  localparam int CMD2_SEL_LO  = 2;
  localparam int CMD2_LEN_LO  = 4;
  localparam int STAT1_BUSY   = 0;
  localparam int STAT1_CDONE  = 1;
  localparam int IRQ_CHAR     = 0;
  localparam int IRQ_FRAME    = 1;
  localparam int NUM_SLAVES   = 4;

  // ==========================================================
  // reset values
  localparam logic [15:0] RST_CLOCK_DIVIDER = 16'h0004;
  localparam logic [15:0] RST_ZERO16        = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_SHIFT = 2'b10,
    ST_TAIL  = 2'b11
  } eng_state_t;

  typedef struct packed {
    logic [15:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [4:0] len_m1;
    logic       loop;
    logic [1:0] sel;
    logic       pol;
    logic       pha;
  } xfer_cfg_t;

  typedef struct packed {
    eng_state_t  st;
    logic [15:0] cdr;
    logic [15:0] ccr;
    logic [15:0] dcr1;
    logic [15:0] dcr2;
    logic [15:0] cmd1;
    logic [15:0] cmd2;
    logic [31:0] txd;
    logic [31:0] rxd;
    logic [1:0]  istat;
    logic [1:0]  imask;
    xfer_cfg_t   cur;
    logic [15:0] cnt;
    logic [6:0]  hcnt;
    logic [2:0]  dcnt;
    logic [31:0] shr;
    logic [31:0] rxs;
    logic [11:0] fcnt;
    logic        cs_act;
    logic        chdone;
    logic        sclk;
    logic        tx;
    logic [3:0]  cs;
    logic        irq;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
  } state_t;

endpackage : spi_master_pkg

// ---- src/spi_master_port.sv ----
// master-only serial port with four selects, APB register slave and irq.
// assumes APB master and slaves share clk_in; rx input is synchronous.
//
// Functional notes
// - character length programmable from 1 to 32 bits
// - each select output has a configurable active level
// - polarity and phase bits pick modes 0 to 3
// - select-to-first-edge delay of 1 to 4 serial clock periods
// - serial clock period is at least four system clocks
// - mode 0 samples receive line on rising serial clock edge
// - mode 1 samples receive line on falling serial clock edge
// - mode 3 samples receive line on rising serial clock edge
// - modes 1 and 2 change transmit line after rising edges
// - modes 0 and 3 change transmit line after falling edges
// - master only; the port always drives the serial clock
// - four separate select outputs, one per slave
// - frame of 1 to 4096 characters, optional per-character interrupt
// - loopback feeds transmitted bits back to the receive path
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module spi_master_port (
  // clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      sys_rst_in,
  // apb slave
  input  wire spi_master_pkg::apb_req_t  apb_in,
  output logic [31:0]                    prdata_out,
  output logic                           pready_out,
  output logic                           pslverr_out,
  // serial link
  output logic                           sclk_out,
  output logic                           tx_out,
  input  wire logic                      rx_in,
  output logic [3:0]                     slave_select_n_out,
  // interrupt
  output logic                           irq_out
);
  import spi_master_pkg::*;

  state_t r;
  state_t n;

  // ==========================================================
  // per-slave configuration lookup
  function automatic logic [4:0] slave_cfg(input logic [15:0] d1,
                                           input logic [15:0] d2,
                                           input logic [1:0]  s);
    logic [15:0] d;
    d = s[1] ? d2 : d1;
    slave_cfg = s[0] ? d[DCR_STRIDE +: 5] : d[4:0];
  endfunction : slave_cfg

  // ==========================================================
  // next state
  always_comb begin
    logic        access;
    logic        wr;
    logic        rd;
    logic        mapped;
    logic [13:0] widx;
    logic [31:0] rmux;
    logic [15:0] half;
    logic        tick;
    logic        lead;
    logic        last;
    logic        rxbit;
    logic        start;
    logic        ev_char;
    logic        ev_frame;
    logic [1:0]  w1c;
    logic [4:0]  scfg;
    logic [5:0]  len;
    logic [2:0]  sel_i;
    n        = r;
    scfg     = 5'h00;
    sel_i    = 3'h0;
    widx     = apb_in.paddr[15:2];
    access   = apb_in.psel & apb_in.penable;
    wr       = access & r.ready & apb_in.pwrite;
    rd       = access & r.ready & ~apb_in.pwrite;
    ev_char  = 1'b0;
    ev_frame = 1'b0;
    w1c      = 2'b00;
    rmux     = 32'h0000_0000;
    mapped   = (apb_in.paddr[1:0] == 2'b00);
    unique case (widx)
      IDX_CLOCK_DIVIDER[13:0]:   rmux = {16'h0000, r.cdr};
      IDX_CLOCK_CONTROL[13:0]:   rmux = {16'h0000, r.ccr};
      IDX_DEVICE_CONFIG_1[13:0]: rmux = {16'h0000, r.dcr1};
      IDX_DEVICE_CONFIG_2[13:0]: rmux = {16'h0000, r.dcr2};
      IDX_COMMAND_1[13:0]:       rmux = {16'h0000, r.cmd1};
      IDX_COMMAND_2[13:0]:       rmux = {16'h0000, r.cmd2};
      IDX_STATUS_1[13:0]: begin
        rmux[STAT1_BUSY]  = (r.st != ST_IDLE);
        rmux[STAT1_CDONE] = r.chdone;
      end
      IDX_STATUS_2[13:0]:   rmux = {20'h00000, r.fcnt};
      IDX_DATA_1[13:0]:     rmux = {16'h0000, r.rxd[15:0]};
      IDX_DATA_2[13:0]:     rmux = {16'h0000, r.rxd[31:16]};
      IDX_IRQ_STATUS[13:0]: rmux = {30'h0, r.istat};
      IDX_IRQ_MASK[13:0]:   rmux = {30'h0, r.imask};
      default:              mapped = 1'b0;
    endcase

    // one wait state: answer in the second access cycle
    n.ready = access & ~r.ready;
    if (access & ~r.ready) begin
      n.err   = ~mapped;
      n.rdata = (mapped & ~apb_in.pwrite) ? rmux : 32'h0000_0000;
    end else begin
      // the answer stands for the ready cycle only, then reads as zero
      n.err   = 1'b0;
      n.rdata = 32'h0000_0000;
    end

    // ==========================================================
    // serial engine
    // a divider below the floor is raised so sclk never beats 4 sysclks
    half = (r.cdr < MIN_HALF) ? MIN_HALF : r.cdr;
    tick = (r.cnt == (half - 16'h0001));
    n.cnt = (r.st == ST_IDLE || tick) ? 16'h0000 : r.cnt + 16'h0001;
    len   = {1'b0, r.cur.len_m1} + 6'd1;
    lead  = ~r.hcnt[0];
    last  = (r.hcnt == ({len, 1'b0} - 7'd1));
    rxbit = r.cur.loop ? r.tx : rx_in;
    start = wr & mapped & (widx == IDX_COMMAND_2[13:0])
          & apb_in.pwdata[CMD2_START] & r.ccr[CCR_ENABLE]
          & (r.st == ST_IDLE);

    unique case (r.st)
      ST_IDLE: begin
        if (start) begin
          scfg          = slave_cfg(r.dcr1, r.dcr2,
                            apb_in.pwdata[CMD2_SEL_LO +: 2]);
          n.cur.len_m1  = apb_in.pwdata[CMD2_LEN_LO +: 5];
          n.cur.loop    = apb_in.pwdata[CMD2_LOOP];
          n.cur.sel     = apb_in.pwdata[CMD2_SEL_LO +: 2];
          n.cur.pol     = scfg[DCR_POL];
          n.cur.pha     = scfg[DCR_PHA];
          n.sclk        = scfg[DCR_POL];
          // left-align the character so the msb leaves first
          n.shr  = r.txd << (5'd31 - apb_in.pwdata[CMD2_LEN_LO +: 5]);
          n.rxs  = 32'h0000_0000;
          n.hcnt = 7'd0;
          if (~scfg[DCR_PHA]) begin
            n.tx  = n.shr[31];
            n.shr = {n.shr[30:0], 1'b0};
          end
          if (r.cs_act) begin
            n.st = ST_SHIFT;
          end else begin
            n.cs_act = 1'b1;
            // odd half count plus first tick: a full period of setup at 0
            n.dcnt = {scfg[DCR_DLY_LO +: 2], 1'b1};
            n.st   = ST_DELAY;
          end
        end
      end
      ST_DELAY: begin
        if (tick) begin
          if (r.dcnt == 3'd1) begin
            n.st = ST_SHIFT;
          end else begin
            n.dcnt = r.dcnt - 3'd1;
          end
        end
      end
      ST_SHIFT: begin
        if (tick) begin
          n.sclk = ~r.sclk;
          // phase 0 samples on the leading edge, phase 1 on trailing
          if (lead ^ r.cur.pha) begin
            n.rxs = {r.rxs[30:0], rxbit};
          end
          if ((r.cur.pha & lead) | (~r.cur.pha & ~lead & ~last)) begin
            n.tx  = r.shr[31];
            n.shr = {r.shr[30:0], 1'b0};
          end
          if (last) begin
            n.st = ST_TAIL;
          end else begin
            n.hcnt = r.hcnt + 7'd1;
          end
        end
      end
      ST_TAIL: begin
        if (tick) begin
          n.rxd    = r.rxs;
          n.chdone = 1'b1;
          ev_char  = 1'b1;
          n.st     = ST_IDLE;
          if (r.fcnt == r.cmd1[CMD1_FLEN_W-1:0]) begin
            n.fcnt   = 12'h000;
            n.cs_act = 1'b0;
            ev_frame = 1'b1;
          end else begin
            n.fcnt = r.fcnt + 12'h001;
          end
        end
      end
    endcase

    // select outputs follow each slave's configured active level
    for (int i = 0; i < NUM_SLAVES; i++) begin
      sel_i   = 3'(i);
      scfg    = slave_cfg(r.dcr1, r.dcr2, sel_i[1:0]);
      n.cs[i] = (r.cs_act & (r.cur.sel == sel_i[1:0]))
              ? scfg[DCR_CS_HIGH] : ~scfg[DCR_CS_HIGH];
    end

    // ==========================================================
    // register writes; hardware set wins over software clear
    if (wr & mapped) begin
      unique case (widx)
        IDX_CLOCK_DIVIDER[13:0]:   n.cdr  = apb_in.pwdata[15:0];
        IDX_CLOCK_CONTROL[13:0]:   n.ccr  = apb_in.pwdata[15:0];
        IDX_DEVICE_CONFIG_1[13:0]: n.dcr1 = apb_in.pwdata[15:0];
        IDX_DEVICE_CONFIG_2[13:0]: n.dcr2 = apb_in.pwdata[15:0];
        IDX_COMMAND_1[13:0]:       n.cmd1 = apb_in.pwdata[15:0];
        IDX_COMMAND_2[13:0]: begin
          n.cmd2 = apb_in.pwdata[15:0];
          n.cmd2[CMD2_START] = 1'b0;
        end
        IDX_DATA_1[13:0]:     n.txd[15:0]  = apb_in.pwdata[15:0];
        IDX_DATA_2[13:0]:     n.txd[31:16] = apb_in.pwdata[15:0];
        IDX_IRQ_STATUS[13:0]: w1c = apb_in.pwdata[1:0];
        IDX_IRQ_MASK[13:0]:   n.imask = apb_in.pwdata[1:0];
        default: ;
      endcase
    end
    if (rd & mapped & (widx == IDX_DATA_1[13:0]) & ~ev_char) begin
      n.chdone = 1'b0;
    end
    n.istat = r.istat & ~w1c;
    n.istat[IRQ_CHAR]  = n.istat[IRQ_CHAR]
                       | (ev_char & r.cmd1[CMD1_CHAR_IE]);
    n.istat[IRQ_FRAME] = n.istat[IRQ_FRAME]
                       | (ev_frame & r.cmd1[CMD1_FRAME_IE]);
    n.irq = |(r.istat & r.imask);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      r       <= '0;
      r.st    <= ST_IDLE;
      r.cdr   <= RST_CLOCK_DIVIDER;
      r.ccr   <= RST_ZERO16;
      r.cs    <= 4'hF;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign prdata_out         = r.rdata;
  assign pready_out         = r.ready;
  assign pslverr_out        = r.err;
  assign sclk_out           = r.sclk;
  assign tx_out             = r.tx;
  assign slave_select_n_out = r.cs;
  assign irq_out            = r.irq;

endmodule : spi_master_port

// ---- testbench/spi_master_port_asserts.sv ----
// checker for the serial master port: apb handshake and serial timing.
// assumes it is bound to spi_master_port and sees only its ports.
`timescale 1ns/1ps
module spi_master_port_asserts (
  // clock and reset
  input wire logic                     clk_in,
  input wire logic                     sys_rst_in,
  // apb
  input wire spi_master_pkg::apb_req_t apb_in,
  input wire logic [31:0]              prdata_out,
  input wire logic                     pready_out,
  input wire logic                     pslverr_out,
  // serial link and interrupt
  input wire logic                     sclk_out,
  input wire logic                     tx_out,
  input wire logic [3:0]               slave_select_n_out,
  input wire logic                     irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // ==========
  // register bus
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  a_one_wait: assert property (apb_in.psel && $rose(apb_in.penable)
    |-> !pready_out ##1 pready_out) else $error("wait state count");
  a_ready_cause: assert property (pready_out
    |-> apb_in.psel && apb_in.penable) else $error("ready without access");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
  // ==========
  // serial link
  a_sclk_half: assert property ($changed(sclk_out) |=> $stable(sclk_out))
    else $error("serial clock half period short");
  a_tx_hold: assert property ($changed(tx_out) |=> $stable(tx_out))
    else $error("transmit bit too short");
  a_reset_idle: assert property ($fell(sys_rst_in)
    |-> slave_select_n_out == 4'hF && !sclk_out && !irq_out)
    else $error("outputs not idle after reset");
endmodule : spi_master_port_asserts

// ---- testbench/spi_slave_model.sv ----
// behavioural slave on the serial link: shifts a reply out, captures tx.
// assumes the bench decodes the select line into sel_in (high = chosen).
`timescale 1ns/1ps
module spi_slave_model (
  // link
  input  wire logic        sclk_in,
  input  wire logic        tx_in,
  input  wire logic        sel_in,
  // mode and reply
  input  wire logic        cpol_in,
  input  wire logic        cpha_in,
  input  wire logic [31:0] resp_in,
  input  wire logic [5:0]  len_in,
  output logic             rx_out,
  output logic [31:0]      got_out
);
  int   idx;
  logic sel_q;
  // one process owns both outputs; select edges are found against sel_q
  always @(sel_in or sclk_in) begin
    if (sel_in === 1'b1 && sel_q !== 1'b1) begin
      idx     = len_in - 1;
      got_out = 32'h0;
      rx_out  = cpha_in ? ~rx_out : resp_in[idx];
    end else if (sel_in !== 1'b1 && sel_q === 1'b1) begin
      // a released line shows the inverse, never a stale bit
      rx_out = ~rx_out;
    end else if (sel_in === 1'b1) begin
      if ((sclk_in != cpol_in) ^ cpha_in) begin
        got_out = {got_out[30:0], tx_in};
      end else if (cpha_in) begin
        rx_out = resp_in[idx];
        idx    = idx - 1;
      end else begin
        idx    = idx - 1;
        rx_out = (idx >= 0) ? resp_in[idx] : ~rx_out;
      end
    end
    sel_q = sel_in;
  end
endmodule : spi_slave_model

// ---- testbench/tb_spi_master_port.sv ----
// bench for spi_master_port: apb tasks, queued read checks, slave model.
// assumes one 10 MHz clock and the one-wait-state apb answer.
`timescale 1ns/1ps
module tb_spi_master_port;
  import spi_master_pkg::*;
  logic        clk_in, sys_rst_in, rx, sclk, tx, irq, rdy, serr, p;
  logic [3:0]  ss_n, hi;
  logic [31:0] rdat, got, resp, txd, ex, msk;
  apb_req_t    apb;
  logic [32:0] exq[$];
  int          m, len, d, h, t, edges, miscompares, n_tests;
  int          lens[4] = '{8, 1, 32, 17};
  spi_master_port spi_master_port_inst (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .apb_in(apb), .prdata_out(rdat),
    .pready_out(rdy), .pslverr_out(serr), .sclk_out(sclk), .tx_out(tx),
    .rx_in(rx), .slave_select_n_out(ss_n), .irq_out(irq));
  spi_slave_model spi_slave_model_inst (.sclk_in(sclk), .tx_in(tx),
    .sel_in(ss_n[m[1:0]] == hi[m[1:0]]), .cpol_in(m[1]), .cpha_in(m[0]),
    .resp_in(resp), .len_in(6'(len)), .rx_out(rx), .got_out(got));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // ==========
  // tasks
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic tick();
    @(posedge clk_in);
    t++;
    if (t > 400) begin
      miscompares++;
      finish_test();
    end
  endtask : tick
  task automatic bus(input logic w, input logic [15:0] i,
                     input logic [31:0] wd, input logic [32:0] e);
    @(posedge clk_in);
    if (!w) exq.push_back(e);
    apb <= '{{i[13:0], 2'b00}, 1'b1, 1'b0, w, wd};
    @(posedge clk_in);
    apb.penable <= 1'b1;
    t = 0;
    do tick(); while (rdy !== 1'b1);
    apb.psel    <= 1'b0;
    apb.penable <= 1'b0;
  endtask : bus
  task automatic wr(input logic [15:0] i, input logic [31:0] v);
    bus(1'b1, i, v, 33'h0);
  endtask : wr
  task automatic rd(input logic [15:0] i, input logic [31:0] v);
    bus(1'b0, i, v, {1'b0, v});
  endtask : rd
  // read answers are compared against the notes in arrival order
  always @(posedge clk_in) begin
    if (apb.psel && apb.penable && rdy === 1'b1 && !apb.pwrite) begin
      check({serr, rdat}, exq.pop_front());
    end
  end
  // ==========
  // sequence
  initial begin
    void'($urandom(52));
    miscompares = 0;
    n_tests     = 0;
    m           = 0;
    len         = 8;
    hi          = 4'h0;
    resp        = 32'h0;
    apb         = '0;
    sys_rst_in  = 1'b1;
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(IDX_CLOCK_DIVIDER, 32'(RST_CLOCK_DIVIDER));
    rd(IDX_STATUS_1, 32'(RST_ZERO16));
    bus(1'b0, 16'h300C, 32'h0, {1'b1, 32'h0});
    wr(IDX_CLOCK_CONTROL, 32'h1);
    wr(IDX_COMMAND_1, 32'hC000);
    for (int k = 0; k < 4; k++) begin
      m    = k;
      len  = lens[k];
      d    = 3 - k;
      h    = (k < 2) ? 2 : k;
      hi   = (k == 2) ? 4'h4 : 4'h0;
      txd  = $urandom;
      resp = $urandom;
      msk  = 32'hFFFF_FFFF >> (32 - len);
      wr(IDX_CLOCK_DIVIDER, k);
      wr(k < 2 ? IDX_DEVICE_CONFIG_1 : IDX_DEVICE_CONFIG_2,
         32'({d[1:0], hi[k], k[0], k[1]}) << (8 * k[0]));
      wr(IDX_DATA_1, 32'(txd[15:0]));
      wr(IDX_DATA_2, 32'(txd[31:16]));
      wr(IDX_IRQ_MASK, (k == 3) ? 32'h0 : 32'h3);
      wr(IDX_COMMAND_2, 32'({5'(len - 1), 2'(k), (k == 1), 1'b1}));
      t = 0;
      while (ss_n[k] !== hi[k]) tick();
      t = 0;
      while (sclk === k[1]) tick();
      // select shows a cycle after start; first edge one period plus d later
      check(t, (2 * d + 2) * h - 1);
      edges = 1;
      p     = sclk;
      t     = 0;
      while (ss_n[k] === hi[k]) begin
        tick();
        edges += (sclk !== p);
        p = sclk;
      end
      check(edges, 2 * len);
      check(sclk, k[1]);
      // characters sit right-aligned in the data registers
      check(got & msk, txd & msk);
      ex = ((k == 1) ? txd : resp) & msk;
      rd(IDX_STATUS_1, 32'h2);
      check(irq, k != 3);
      rd(IDX_IRQ_STATUS, 32'h3);
      rd(IDX_DATA_1, 32'(ex[15:0]));
      rd(IDX_DATA_2, 32'(ex[31:16]));
      rd(IDX_STATUS_1, 32'h0);
      if (k == 3) begin
        wr(IDX_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk_in);
        check(irq, 1'b1);
      end
      wr(IDX_IRQ_STATUS, 32'h3);
      rd(IDX_IRQ_STATUS, 32'h0);
      check(irq, 1'b0);
    end
    // two-character frame on slave 3: select holds between characters
    wr(IDX_COMMAND_1, 32'h4001);
    for (int c = 0; c < 2; c++) begin
      wr(IDX_COMMAND_2, 32'({5'(len - 1), 2'h3, 1'b0, 1'b1}));
      t = 0;
      do tick(); while (irq !== 1'b1);
      check(ss_n[3], c == 1);
      rd(IDX_STATUS_2, 32'(1 - c));
      rd(IDX_IRQ_STATUS, 32'h1);
      wr(IDX_IRQ_STATUS, 32'h1);
    end
    finish_test();
  end
endmodule : tb_spi_master_port
bind spi_master_port spi_master_port_asserts spi_master_port_asserts_inst (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .apb_in(apb_in),
  .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .sclk_out(sclk_out), .tx_out(tx_out),
  .slave_select_n_out(slave_select_n_out), .irq_out(irq_out));
